/* logic/eps_cause_mem.sv */
// eps_cause_mem: retained record of the last shutdown cause or sensing-loss alarm.
// assumes reset_n models power-up; the stored word survives it.
`timescale 1ns/1ps
module eps_cause_mem
    import eps_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic reset_n,
    eps_nv_if.mem     nv
);
    typedef struct packed {
        eps_cause_t store;
        eps_cause_t rd;
    } eps_mem_t;

    eps_mem_t q;
    eps_mem_t d;

    always_comb begin
        d    = q;
        d.rd = q.store;
        if (nv.wrEn) begin
            d.store = nv.wrCause;
        end
    end

    // storage is left out of reset on purpose: it stands for the
    // non-volatile cell that outlives a loss of operating power
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            q.rd <= CS_NONE;
        end else begin
            q <= d;
        end
    end

    assign nv.rdCause = q.rd;
endmodule : eps_cause_mem

/* logic/eps_delay_timer.sv */
// eps_delay_timer: counts time-base ticks while its cause is present.
// assumes tick is a one-cycle enable on ref_clk.
`timescale 1ns/1ps
module eps_delay_timer
    import eps_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    input  wire logic          tick,
    input  wire logic          run,
    input  wire logic [TW-1:0] limit,
    output logic               done
);
    typedef struct packed {
        logic [TW-1:0] cnt;
    } eps_tmr_t;

    eps_tmr_t q;
    eps_tmr_t d;

    always_comb begin
        d = q;
        if (!run) begin
            d.cnt = '0;
        end else if (tick && q.cnt < limit) begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // a zero limit expires at once
    assign done = run && (q.cnt >= limit);
endmodule : eps_delay_timer

/* logic/eps_nv_if.sv */
// eps_nv_if: link between the sequencer and its retained cause store.
// assumes both ends run on ref_clk.
`timescale 1ns/1ps
interface eps_nv_if;
    import eps_pkg::*;
    logic       wrEn;
    eps_cause_t wrCause;
    eps_cause_t rdCause;
    modport host (output wrEn, output wrCause, input rdCause);
    modport mem  (input wrEn, input wrCause, output rdCause);
endinterface : eps_nv_if

/* logic/eps_pkg.sv */
// eps_pkg: constants and types of the excitation protection sequencer.
// assumes a 40 MHz ref_clk and a centisecond time base.
package eps_pkg;
    localparam int unsigned CLK_HZ  = 40_000_000;
    localparam int unsigned TICK_HZ = 100;
    localparam int unsigned TW      = 20;
    localparam int unsigned NT      = 6;
    localparam int unsigned T_LOS   = 0;
    localparam int unsigned T_FOV   = 1;
    localparam int unsigned T_OVX   = 2;
    localparam int unsigned T_UNX   = 3;
    localparam int unsigned T_SS    = 4;
    localparam int unsigned T_RPL   = 5;

    localparam int unsigned LOS_DLY_MAX_S = 25;
    localparam int unsigned LOS_DLY_DEF_S = 10;
    localparam int unsigned FOV_DLY_S     = 10;
    localparam int unsigned REPLAY_S      = 5;
    localparam int unsigned LIM_DLY_MAX_S = 10;
    localparam logic [TW-1:0] LOS_DLY_MAX = TW'(LOS_DLY_MAX_S * TICK_HZ);
    localparam logic [TW-1:0] LOS_DLY_DEF = TW'(LOS_DLY_DEF_S * TICK_HZ);
    localparam logic [TW-1:0] FOV_DLY     = TW'(FOV_DLY_S * TICK_HZ);
    localparam logic [TW-1:0] REPLAY_DLY  = TW'(REPLAY_S * TICK_HZ);
    localparam logic [TW-1:0] LIM_DLY_MAX = TW'(LIM_DLY_MAX_S * TICK_HZ);
    localparam logic [6:0]    TICKS_PER_S = 7'h64;
    localparam logic [12:0]   SS_MIN_S    = 13'h0001;
    localparam logic [12:0]   SS_MAX_S    = 13'h1C20;
    localparam logic [14:0]   MATCH_MIN   = 15'h0064;
    localparam logic [14:0]   MATCH_MAX   = 15'h7530;

    // field volts in 0.1 V, field amps in 0.01 A, frequency in 0.1 Hz
    localparam logic [11:0] FOV_MAX   = 12'h9C4;
    localparam logic [11:0] OVX_MAX   = 12'h5DC;
    localparam logic [9:0]  FREQ_MIN  = 10'h078;
    localparam logic [1:0]  NPH       = 2'h3;
    localparam logic [1:0]  SC_MULT   = 2'h3;
    localparam logic [1:0]  LOS_DIV   = 2'h2;
    localparam logic [2:0]  DEV_DIV   = 3'h5;
    localparam logic [3:0]  MATCH_DIV = 4'hA;
    localparam logic [6:0]  PCT_FULL  = 7'h64;
    localparam logic [6:0]  UNX_MAX   = 7'h64;
    localparam logic [8:0]  SQRT3_Q8  = 9'h1BB;
    localparam logic [8:0]  Q8_ONE    = 9'h100;
    localparam logic [2:0]  INOM_LO   = 3'h1;
    localparam logic [2:0]  INOM_HI   = 3'h5;
    localparam int unsigned ACT_RELAY = 0;
    localparam int unsigned ACT_SHUT  = 1;
    localparam int unsigned SEL_TIE   = 0;
    localparam int unsigned SEL_PC    = 1;

    typedef enum logic [2:0] {
        ST_REPLAY = 3'h1,
        ST_RUN    = 3'h2,
        ST_SHUT   = 3'h4
    } eps_state_t;

    typedef enum logic [2:0] {
        CS_NONE = 3'h0,
        CS_LOS  = 3'h1,
        CS_FOV  = 3'h2,
        CS_OVX  = 3'h3,
        CS_UNX  = 3'h4
    } eps_cause_t;
endpackage : eps_pkg

/* logic/eps_sequencer.sv */
// eps_sequencer: protection and supervisory sequencer of an exciter.
// assumes measurements arrive on ref_clk; breaker contacts are pins.
`timescale 1ns/1ps
module eps_sequencer
    import eps_pkg::*;
#(
    parameter int unsigned TICK_CYC = CLK_HZ / TICK_HZ
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        cfgThreePhase,
    input  wire logic [15:0] cfgRatedV,
    input  wire logic [15:0] vAb,
    input  wire logic [15:0] vBc,
    input  wire logic [15:0] vCa,
    input  wire logic [9:0]  freqDhz,
    input  wire logic [15:0] phaseBCur,
    input  wire logic [15:0] cfgPhaseBPu,
    input  wire logic [19:0] cfgLosDelay,
    input  wire logic        cfgLosTransfer,
    input  wire logic        modeReleaseReq,
    input  wire logic [11:0] fieldV,
    input  wire logic [11:0] cfgFovSp,
    input  wire logic [1:0]  cfgFovAct,
    input  wire logic [11:0] fieldI,
    input  wire logic [11:0] cfgOvxSp,
    input  wire logic [11:0] cfgExcSp,
    input  wire logic [19:0] cfgLimDelay,
    input  wire logic        cfgTakeover,
    input  wire logic        cfgOvxShut,
    input  wire logic [23:0] leadVars,
    input  wire logic [6:0]  cfgUnxPct,
    input  wire logic        cfgRating5A,
    input  wire logic [19:0] cfgUnxDelay,
    input  wire logic        cfgUnxShut,
    input  wire logic        tieBreakerPin,
    input  wire logic        parallelCompPin,
    input  wire logic [12:0] cfgSoftStartS,
    input  wire logic [15:0] vBus,
    input  wire logic [15:0] cfgBusNom,
    input  wire logic [14:0] cfgMatchSpeed,
    input  wire logic [1:0]  cfgMatchSel,
    input  wire logic        cfgMaintain,
    output logic             alarmRelayClosed,
    output logic             indSenseLoss,
    output logic             indOvxShutdown,
    output logic             indOvxLimit,
    output logic             indUnxLimit,
    output logic             excDisable,
    output logic             fieldCurMode,
    output logic             takeoverLimit,
    output logic             softStartActive,
    output logic             matchEnable,
    output logic             matchStep,
    output logic             varPfEnable,
    output logic             holdBusSetpoint
);
    typedef struct packed {
        eps_state_t  st;
        logic        tieS1;
        logic        tieS2;
        logic        pcS1;
        logic        pcS2;
        logic [19:0] tickCnt;
        logic        tick;
        logic        losLatch;
        logic        curMode;
        logic        hold;
        logic        losPrev;
        logic [14:0] mCnt;
        logic        mStep;
        logic        relay;
        logic        indLos;
        logic        indFov;
        logic        indOvx;
        logic        indUnx;
        logic        takeover;
        logic        ssAct;
        logic        mEn;
        logic        varPf;
    } eps_regs_t;

    eps_regs_t q;
    eps_regs_t d;

    logic          tRun  [NT];
    logic [TW-1:0] tLim  [NT];
    logic [NT-1:0] tDone;

    eps_nv_if nv ();

    eps_cause_mem u_mem (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .nv      (nv.mem)
    );

    for (genvar i = 0; i < NT; i++) begin : g_tmr
        eps_delay_timer u_tmr (
            .ref_clk (ref_clk),
            .reset_n (reset_n),
            .tick    (q.tick),
            .run     (tRun[i]),
            .limit   (tLim[i]),
            .done    (tDone[i])
        );
    end

    function automatic logic devHigh(
        input logic [15:0] v,
        input logic [17:0] s,
        input logic [18:0] r3
    );
        logic [18:0] v3;
        logic [18:0] diff;
        v3   = 19'(v) * 19'(NPH);
        diff = (v3 > 19'(s)) ? v3 - 19'(s) : 19'(s) - v3;
        return (22'(diff) * 22'(DEV_DIV)) > 22'(r3);
    endfunction : devHigh

    logic [17:0] vSum;
    logic [18:0] rated3;
    logic        losRaw;
    logic        inhibit;
    logic        losDet;
    logic        alive;
    logic        tieClosed;
    logic        pcClosed;
    logic [11:0] fovSp;
    logic [11:0] ovxSp;
    logic [11:0] excSp;
    logic [11:0] limSp;
    logic        fovCond;
    logic        ovxCond;
    logic        unxCond;
    logic        unxEn;
    logic [41:0] varLhs;
    logic [41:0] varRhs;
    logic [6:0]  unxPct;
    logic [2:0]  inom;
    logic [12:0] ssSec;
    logic [14:0] mSpd;
    logic [15:0] busDiff;
    logic        busIn;
    logic        matchOff;
    logic        anyAlarm;
    logic        shutNow;
    eps_cause_t  shutCause;
    eps_cause_t  rpl;

    assign vSum   = 18'(vAb) + 18'(vBc) + 18'(vCa);
    assign rated3 = 19'(cfgRatedV) * 19'(NPH);
    assign alive  = (q.st != ST_SHUT);
    assign tieClosed = q.tieS2;
    assign pcClosed  = q.pcS2;

    always_comb begin
        if (cfgThreePhase) begin
            losRaw = ((19'(vSum) * 19'(LOS_DIV)) < rated3)
                || (vAb == '0) || (vBc == '0) || (vCa == '0)
                || devHigh(vAb, vSum, rated3)
                || devHigh(vBc, vSum, rated3)
                || devHigh(vCa, vSum, rated3);
        end else begin
            losRaw = (17'(vAb) * 17'(LOS_DIV)) < 17'(cfgRatedV);
        end
    end

    // soft start inhibit also covers the restart after a shutdown
    assign inhibit = (freqDhz < FREQ_MIN)
        || (18'(phaseBCur) > 18'(cfgPhaseBPu) * 18'(SC_MULT))
        || !tDone[T_SS];
    assign losDet = losRaw && !inhibit && alive;

    assign fovSp = (cfgFovSp > FOV_MAX) ? FOV_MAX : cfgFovSp;
    assign fovCond = alive && (fieldV > fovSp);

    assign ovxSp = (cfgOvxSp > OVX_MAX) ? OVX_MAX : cfgOvxSp;
    assign excSp = (cfgExcSp > ovxSp) ? ovxSp : cfgExcSp;
    // a closed tie contact selects the second limiter setpoint
    assign limSp = tieClosed ? excSp : ovxSp;
    assign ovxCond = alive && (fieldI > limSp);

    assign unxEn  = !tieClosed || !pcClosed;
    assign unxPct = (cfgUnxPct > UNX_MAX) ? UNX_MAX : cfgUnxPct;
    assign inom   = cfgRating5A ? INOM_HI : INOM_LO;
    assign varLhs = 42'(leadVars) * 42'(PCT_FULL) * 42'(Q8_ONE)
                  * 42'(NPH);
    assign varRhs = 42'(vSum) * 42'(inom) * 42'(SQRT3_Q8)
                  * 42'(unxPct);
    assign unxCond = alive && unxEn && (varLhs > varRhs);

    assign ssSec = (cfgSoftStartS < SS_MIN_S) ? SS_MIN_S :
                   (cfgSoftStartS > SS_MAX_S) ? SS_MAX_S : cfgSoftStartS;
    assign mSpd  = (cfgMatchSpeed < MATCH_MIN) ? MATCH_MIN :
                   (cfgMatchSpeed > MATCH_MAX) ? MATCH_MAX : cfgMatchSpeed;
    assign busDiff = (vBus > cfgBusNom) ? vBus - cfgBusNom
                                        : cfgBusNom - vBus;
    assign busIn = (20'(busDiff) * 20'(MATCH_DIV)) <= 20'(cfgBusNom);
    assign matchOff = (cfgMatchSel[SEL_TIE] && tieClosed)
                   || (cfgMatchSel[SEL_PC] && pcClosed);

    always_comb begin
        tRun[T_LOS] = losDet;
        tLim[T_LOS] = (cfgLosDelay > LOS_DLY_MAX) ? LOS_DLY_DEF
                                                  : cfgLosDelay;
        tRun[T_FOV] = fovCond;
        tLim[T_FOV] = FOV_DLY;
        tRun[T_OVX] = ovxCond;
        tLim[T_OVX] = (cfgLimDelay > LIM_DLY_MAX) ? LIM_DLY_MAX
                                                  : cfgLimDelay;
        tRun[T_UNX] = unxCond;
        tLim[T_UNX] = (cfgUnxDelay > LIM_DLY_MAX) ? LIM_DLY_MAX
                                                  : cfgUnxDelay;
        tRun[T_SS]  = 1'b1;
        tLim[T_SS]  = 20'(ssSec) * 20'(TICKS_PER_S);
        tRun[T_RPL] = (q.st == ST_REPLAY);
        tLim[T_RPL] = REPLAY_DLY;
    end

    // shutdown sources in fixed priority; the first one is recorded
    always_comb begin
        shutNow   = 1'b1;
        shutCause = CS_NONE;
        if (losDet && tDone[T_LOS] && !cfgLosTransfer) begin
            shutCause = CS_LOS;
        end else if (tDone[T_FOV] && cfgFovAct[ACT_SHUT]) begin
            shutCause = CS_FOV;
        end else if (tDone[T_OVX] && cfgOvxShut) begin
            shutCause = CS_OVX;
        end else if (tDone[T_UNX] && cfgUnxShut) begin
            shutCause = CS_UNX;
        end else begin
            shutNow = 1'b0;
        end
    end

    assign rpl = (q.st == ST_REPLAY) ? nv.rdCause : CS_NONE;
    assign anyAlarm = losDet
        || (tDone[T_FOV] && cfgFovAct[ACT_RELAY])
        || (tDone[T_OVX] && !cfgTakeover)
        || tDone[T_UNX];

    always_comb begin
        d       = q;
        d.tieS1 = tieBreakerPin;
        d.tieS2 = q.tieS1;
        d.pcS1  = parallelCompPin;
        d.pcS2  = q.pcS1;
        d.tick  = 1'b0;
        d.tickCnt = q.tickCnt + 1'b1;
        if (q.tickCnt == 20'(TICK_CYC - 1)) begin
            d.tickCnt = '0;
            d.tick    = 1'b1;
        end

        nv.wrEn    = 1'b0;
        nv.wrCause = CS_NONE;
        case (q.st)
            ST_REPLAY: begin
                if (shutNow) begin
                    d.st = ST_SHUT;
                end else if (tDone[T_RPL]) begin
                    d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (shutNow) begin
                    d.st = ST_SHUT;
                end
            end
            ST_SHUT: begin
                d.st = ST_SHUT;
            end
            default: begin
                d.st = ST_REPLAY;
            end
        endcase

        d.losPrev = losDet;
        if (shutNow && alive) begin
            nv.wrEn    = 1'b1;
            nv.wrCause = shutCause;
        end else if (losDet && !q.losPrev) begin
            nv.wrEn    = 1'b1;
            nv.wrCause = CS_LOS;
        end else if (q.st == ST_REPLAY && tDone[T_RPL]) begin
            nv.wrEn    = 1'b1;
            nv.wrCause = CS_NONE;
        end

        if (losDet) begin
            d.losLatch = 1'b1;
        end else if (!losRaw) begin
            d.losLatch = 1'b0;
        end
        // the set beats a release request in the same cycle
        if (losDet && tDone[T_LOS] && cfgLosTransfer) begin
            d.curMode = 1'b1;
        end else if (modeReleaseReq) begin
            d.curMode = 1'b0;
        end

        d.mEn = alive && busIn && !matchOff;
        d.mStep = 1'b0;
        if (!d.mEn) begin
            d.mCnt = '0;
        end else if (q.tick) begin
            d.mCnt = q.mCnt + 1'b1;
            if (q.mCnt + 1'b1 >= mSpd) begin
                d.mCnt  = '0;
                d.mStep = 1'b1;
            end
        end
        d.hold = q.mEn || (q.hold && cfgMaintain);
        d.varPf = tieClosed;

        d.relay  = alive && !anyAlarm;
        d.indLos = q.losLatch || losDet || (rpl == CS_LOS);
        d.indFov = tDone[T_FOV] || (rpl == CS_FOV);
        d.indOvx = ovxCond || (rpl == CS_OVX);
        d.indUnx = unxCond || (rpl == CS_UNX);
        d.takeover = ovxCond && cfgTakeover;
        d.ssAct  = !tDone[T_SS];
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            q    <= '0;
            q.st <= ST_REPLAY;
        end else begin
            q <= d;
        end
    end

    assign alarmRelayClosed = q.relay;
    assign indSenseLoss     = q.indLos;
    assign indOvxShutdown   = q.indFov;
    assign indOvxLimit      = q.indOvx;
    assign indUnxLimit      = q.indUnx;
    assign excDisable       = (q.st == ST_SHUT);
    assign fieldCurMode     = q.curMode;
    assign takeoverLimit    = q.takeover;
    assign softStartActive  = q.ssAct;
    assign matchEnable      = q.mEn;
    assign matchStep        = q.mStep;
    assign varPfEnable      = q.varPf;
    assign holdBusSetpoint  = q.hold;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_relay_on_loss: assert property (losDet |=> !alarmRelayClosed)
        else $error("relay stayed closed on sensing loss");
    a_relay_recloses: assert property (
        (alive && !anyAlarm) ##1 (alive && !anyAlarm) |=> alarmRelayClosed)
        else $error("relay latched open without alarm");
    a_mode_cause: assert property (
        $rose(fieldCurMode) |-> $past(cfgLosTransfer && tDone[T_LOS]))
        else $error("field-current mode entered without cause");
    a_mode_holds: assert property (
        fieldCurMode && !modeReleaseReq |=> fieldCurMode)
        else $error("field-current mode left without request");
    a_shut_stays: assert property (excDisable |=> excDisable)
        else $error("shutdown released without power cycle");
    a_loss_inhibit: assert property (
        $rose(q.losLatch) |-> $past(tDone[T_SS] && freqDhz >= FREQ_MIN))
        else $error("sensing loss seen while inhibited");
    a_fov_hold: assert property (tDone[T_FOV] |-> fieldV > fovSp)
        else $error("field overvoltage action without overvoltage");
    a_unx_parallel: assert property (
        $rose(indUnxLimit) && q.st == ST_RUN
            |-> $past(!q.tieS2 || !q.pcS2))
        else $error("underexcitation seen outside parallel");
    a_limit_order: assert property (excSp <= ovxSp)
        else $error("second setpoint above first");
    a_match_window: assert property (matchEnable |-> $past(busIn))
        else $error("matching enabled outside window");
    a_replay_end: assert property (
        q.st == ST_REPLAY ##1 q.st == ST_RUN |-> $past(tDone[T_RPL]))
        else $error("replay ended early");

    c_loss_shut: cover property ($rose(excDisable) && q.indLos);
    c_mode_xfer: cover property ($rose(fieldCurMode));
    c_match_step: cover property (matchStep);
    c_unx_alarm: cover property (indUnxLimit && !alarmRelayClosed);
endmodule : eps_sequencer

/* sim/eps_gen_model.sv */
// eps_gen_model: generator sensing, field and contact source.
// assumes bench commands change on the falling edge of ref_clk.
`timescale 1ns/1ps
module eps_gen_model
    import eps_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic losCmd,
    input  wire logic fovCmd,
    output logic [15:0] vAb, vBc, vCa, phaseBCur, vBus,
    output logic [9:0]  freqDhz,
    output logic [11:0] fieldV, fieldI,
    output logic [23:0] leadVars,
    output logic        tieBreakerPin, parallelCompPin
);
    // loss level sits one step under half of rated
    assign vAb = losCmd ? 16'h007F : 16'h0100;
    assign fieldV = fovCmd ? 12'h201 : 12'h100;
    assign {vBc, vCa, vBus} = {3{16'h0100}};
    assign phaseBCur = 16'h0000;
    assign freqDhz = 10'h258;
    assign fieldI = 12'h000;
    assign leadVars = 24'h000000;
    // both breakers closed: stand-alone unit
    assign {tieBreakerPin, parallelCompPin} = 2'h3;
endmodule : eps_gen_model

/* sim/excitation_protection_sequencer_tb.sv */
// excitation_protection_sequencer_tb: protection sequencing checks.
// assumes TICK_CYC of 4, so one centisecond is four clocks.
`timescale 1ns/1ps
module excitation_protection_sequencer_tb;
    import eps_pkg::*;
    logic ref_clk = 0, reset_n = 0, losCmd = 0, fovCmd = 0;
    logic cfgThreePhase = 0, cfgLosTransfer = 0, modeReleaseReq = 0;
    logic cfgTakeover = 0, cfgOvxShut = 0, cfgRating5A = 0;
    logic cfgUnxShut = 0, cfgMaintain = 0;
    logic [15:0] cfgRatedV = 16'h0100, cfgPhaseBPu = 16'h0100;
    logic [15:0] cfgBusNom = 16'h0100;
    logic [19:0] cfgLosDelay = 20'h00014, cfgLimDelay = 20'h00064;
    logic [19:0] cfgUnxDelay = 20'h00064;
    logic [11:0] cfgFovSp = 12'h200, cfgOvxSp = 12'h5DC, cfgExcSp = 12'h5DC;
    logic [1:0]  cfgFovAct = 2'h1, cfgMatchSel = 2'h1;
    logic [6:0]  cfgUnxPct = 7'h32;
    logic [12:0] cfgSoftStartS = 13'h0001;
    logic [14:0] cfgMatchSpeed = 15'h0064;
    logic [15:0] vAb, vBc, vCa, phaseBCur, vBus;
    logic [9:0]  freqDhz;
    logic [11:0] fieldV, fieldI;
    logic [23:0] leadVars;
    logic tieBreakerPin, parallelCompPin, alarmRelayClosed, indSenseLoss;
    logic indOvxShutdown, indOvxLimit, indUnxLimit, excDisable;
    logic fieldCurMode, takeoverLimit, softStartActive, matchEnable;
    logic matchStep, varPfEnable, holdBusSetpoint;
    int failures = 0, samples_checked = 0, cyc = 0;

    eps_sequencer #(.TICK_CYC(4)) eps_sequencer_inst (.*);
    eps_gen_model eps_gen_model_inst (.*);

    initial forever #12.5 ref_clk = ~ref_clk;

    task automatic check(string nm, logic seen, logic exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %b seen %b", nm, exp, seen);
        end
    endtask : check

    task automatic w(int n);
        repeat (n) @(negedge ref_clk);
    endtask : w

    // power-up: three low cycles of reset, which clears the contact synchronisers to open
    task automatic power_up;
        reset_n = 0;
        w(3);
        reset_n = 1;
    endtask : power_up

    task automatic end_sim;
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task automatic t_start;
        w(2);
        check("relay", alarmRelayClosed, 1'b1);
        check("soft", softStartActive, 1'b1);
        w(418);
        check("soft end", softStartActive, 1'b0);
        check("varpf", varPfEnable, 1'b1);
        check("match off", matchEnable, 1'b0);
        check("takeover", takeoverLimit, 1'b0);
        check("unx idle", indUnxLimit, 1'b0);
        check("ovx idle", indOvxLimit, 1'b0);
        $display("test start done");
    endtask : t_start

    // 20 cs delay is 80 clocks; shutdown must not come early
    task automatic t_los_shut;
        losCmd = 1;
        w(3);
        check("los ind", indSenseLoss, 1'b1);
        check("los relay", alarmRelayClosed, 1'b0);
        w(70);
        check("los early", excDisable, 1'b0);
        w(20);
        check("los shut", excDisable, 1'b1);
        losCmd = 0;
        $display("test los_shut done");
    endtask : t_los_shut

    task automatic t_replay;
        power_up();
        w(3);
        check("replay on", indSenseLoss, 1'b1);
        w(1985);
        check("replay hold", indSenseLoss, 1'b1);
        w(25);
        check("replay off", indSenseLoss, 1'b0);
        $display("test replay done");
    endtask : t_replay

    // a brief drop midway must restart the fixed ten second count
    task automatic t_fov;
        fovCmd = 1;
        w(2000);
        fovCmd = 0;
        w(2);
        fovCmd = 1;
        w(3990);
        check("fov early", indOvxShutdown, 1'b0);
        check("fov relay", alarmRelayClosed, 1'b1);
        w(30);
        check("fov ind", indOvxShutdown, 1'b1);
        check("fov open", alarmRelayClosed, 1'b0);
        check("fov run", excDisable, 1'b0);
        fovCmd = 0;
        w(3);
        check("relay back", alarmRelayClosed, 1'b1);
        $display("test fov done");
    endtask : t_fov

    // transfer choice: no shutdown, mode holds until released
    task automatic t_xfer;
        cfgLosTransfer = 1;
        losCmd = 1;
        w(3);
        check("xfer relay", alarmRelayClosed, 1'b0);
        check("xfer ind", indSenseLoss, 1'b1);
        w(100);
        check("xfer mode", fieldCurMode, 1'b1);
        check("xfer run", excDisable, 1'b0);
        losCmd = 0;
        w(3);
        check("xfer clear", indSenseLoss, 1'b0);
        check("xfer stay", fieldCurMode, 1'b1);
        check("xfer relay back", alarmRelayClosed, 1'b1);
        modeReleaseReq = 1;
        w(1);
        modeReleaseReq = 0;
        w(2);
        check("xfer release", fieldCurMode, 1'b0);
        $display("test xfer done");
    endtask : t_xfer

    // no contact selected: bus in window, step after 100 ticks
    task automatic t_match;
        logic stepSeen;
        stepSeen = 0;
        cfgMatchSel = 2'h0;
        w(3);
        check("match on", matchEnable, 1'b1);
        check("match hold", holdBusSetpoint, 1'b1);
        repeat (420) begin
            w(1);
            if (matchStep === 1'b1) stepSeen = 1;
        end
        check("match step", stepSeen, 1'b1);
        cfgMatchSel = 2'h1;
        w(3);
        check("match tie", matchEnable, 1'b0);
        check("revert", holdBusSetpoint, 1'b0);
        $display("test match done");
    endtask : t_match

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end

    initial begin
        power_up();
        t_start();
        t_los_shut();
        t_replay();
        t_fov();
        t_xfer();
        t_match();
        end_sim();
    end
endmodule : excitation_protection_sequencer_tb
